// ---- design/fcs_host.sv ----
// Host controller that drives a byte-wide parallel flash through its pins.
// Assumes software on an Avalon-MM slave port and a flash on the same board.
//
// Our own choices: the placing of the registers and register access over Avalon-MM.
module fcs_host #(
   parameter int POLL_MAX = 4000
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [1:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic      [17:0] flash_addr,
   output logic      [7:0]  flash_dq_o,
   output logic             flash_dq_oe,
   input  wire logic [7:0]  flash_dq_i,
   output logic             flash_ce_n,
   output logic             flash_we_n,
   output logic             flash_oe_n,
   output logic             flash_reset_n,
   input  wire logic        flash_ready_busy_n
);
   if (POLL_MAX < 2 || POLL_MAX > 65535) begin : g_poll_max_chk
      $error("POLL_MAX out of range");
   end

   typedef enum logic [3:0] {
      S_IDLE, S_RST_LOW, S_RST_REC, S_WR_SET, S_WR_PULSE, S_WR_HOLD, S_WR_END,
      S_RD_WAIT, S_RD_GAP
   } fcs_fsm_t;

   typedef struct packed {
      fcs_fsm_t    st;
      logic [2:0]  op;
      logic [1:0]  step;
      logic [15:0] cnt;
      logic [15:0] polls;
      logic        polling;
      logic        first;
      logic [7:0]  prev;
      logic [17:0] addr_reg;
      logic [7:0]  wdata_reg;
      logic [7:0]  rdata;
      logic        done;
      logic        fail;
      logic [7:0]  dq_s1;
      logic [7:0]  dq_s2;
      logic        rb_s1;
      logic        rb_s2;
      logic [17:0] f_addr;
      logic [7:0]  f_dq;
      logic        f_dq_oe;
      logic        f_ce_n;
      logic        f_we_n;
      logic        f_oe_n;
      logic        f_rst_n;
      logic        waitreq;
      logic [31:0] bus_rdata;
   } fcs_state_t;

   fcs_state_t s_q;
   fcs_state_t s_d;

   // Address and data of one write cycle of a command sequence
   function automatic logic [25:0] seq_word(input logic [2:0] op, input logic [1:0] step,
                                            input logic [17:0] tgt, input logic [7:0] dat);
      logic [7:0] cmd;
      cmd = (op == fcs_pkg::OP_PROG) ? fcs_pkg::CMD_PROGRAM :
            (op == fcs_pkg::OP_ID)   ? fcs_pkg::CMD_ID_READ : fcs_pkg::CMD_READ_RESET;
      unique case (step)
         2'h0: seq_word = {fcs_pkg::UNLOCK1_ADDR, fcs_pkg::UNLOCK1_DATA};
         2'h1: seq_word = {fcs_pkg::UNLOCK2_ADDR, fcs_pkg::UNLOCK2_DATA};
         2'h2: seq_word = {fcs_pkg::UNLOCK1_ADDR, cmd};
         2'h3: seq_word = {tgt, dat};
      endcase
   endfunction

   // Next state: synchronisers, bus slave and pin sequencer
   always_comb begin
      s_d = s_q;
      s_d.dq_s1 = flash_dq_i;
      s_d.dq_s2 = s_q.dq_s1;
      s_d.rb_s1 = flash_ready_busy_n;
      s_d.rb_s2 = s_q.rb_s1;
      // One wait cycle per access; readdata is loaded as waitrequest drops
      s_d.waitreq = !((avs_read || avs_write) && s_q.waitreq);
      if (avs_read && s_q.waitreq) begin
         unique case (avs_address)
            fcs_pkg::REG_CTRL:   s_d.bus_rdata = {29'h0, s_q.op};
            fcs_pkg::REG_ADDR:   s_d.bus_rdata = {14'h0, s_q.addr_reg};
            fcs_pkg::REG_WDATA:  s_d.bus_rdata = {24'h0, s_q.wdata_reg};
            fcs_pkg::REG_STATUS: s_d.bus_rdata = {20'h0, s_q.rb_s2, s_q.fail, s_q.done,
                                                  s_q.st != S_IDLE, s_q.rdata};
         endcase
      end
      // Operands are frozen while an operation runs
      if (avs_write && !s_q.waitreq && s_q.st == S_IDLE) begin
         if (avs_address == fcs_pkg::REG_ADDR) s_d.addr_reg = avs_writedata[17:0];
         if (avs_address == fcs_pkg::REG_WDATA) s_d.wdata_reg = avs_writedata[7:0];
      end
      unique case (s_q.st)
         S_IDLE: begin
            if (avs_write && !s_q.waitreq && avs_address == fcs_pkg::REG_CTRL &&
                avs_writedata[2:0] <= fcs_pkg::OP_HWRST) begin
               s_d.op   = avs_writedata[2:0];
               s_d.step = 2'h0;
               s_d.done = 1'b0;
               s_d.fail = 1'b0;
               s_d.cnt  = 16'h0;
               if (avs_writedata[2:0] == fcs_pkg::OP_HWRST) begin
                  s_d.st      = S_RST_LOW;
                  s_d.f_rst_n = 1'b0;
               end else if (avs_writedata[2:0] == fcs_pkg::OP_READ) begin
                  s_d.st      = S_RD_WAIT;
                  s_d.polling = 1'b0;
                  s_d.f_addr  = s_q.addr_reg;
                  s_d.f_ce_n  = 1'b0;
                  s_d.f_oe_n  = 1'b0;
               end else begin
                  s_d.st = S_WR_SET;
               end
            end
         end
         S_RST_LOW: begin
            s_d.cnt = s_q.cnt + 16'h1;
            if (s_q.cnt == 16'(fcs_pkg::RST_LOW_CYC - 1)) begin
               s_d.f_rst_n = 1'b1;
               s_d.cnt     = 16'h0;
               s_d.st      = S_RST_REC;
            end
         end
         S_RST_REC: begin
            // No strobe until the flash can serve reads again
            s_d.cnt = s_q.cnt + 16'h1;
            if (s_q.cnt == 16'(fcs_pkg::RST_REC_CYC - 1)) begin
               s_d.st   = S_IDLE;
               s_d.done = 1'b1;
            end
         end
         S_WR_SET: begin
            {s_d.f_addr, s_d.f_dq} = seq_word(s_q.op, s_q.step, s_q.addr_reg, s_q.wdata_reg);
            s_d.f_dq_oe = 1'b1;
            s_d.f_ce_n  = 1'b0;
            s_d.st      = S_WR_PULSE;
         end
         S_WR_PULSE: begin
            s_d.f_we_n = 1'b0;
            s_d.st     = S_WR_HOLD;
         end
         S_WR_HOLD: begin
            // Data stays driven past the rising strobe edge
            s_d.f_we_n = 1'b1;
            s_d.st     = S_WR_END;
         end
         S_WR_END: begin
            s_d.f_ce_n  = 1'b1;
            s_d.f_dq_oe = 1'b0;
            if (s_q.step == ((s_q.op == fcs_pkg::OP_PROG) ? 2'h3 : 2'h2)) begin
               if (s_q.op == fcs_pkg::OP_RSTCMD) begin
                  s_d.st   = S_IDLE;
                  s_d.done = 1'b1;
               end else begin
                  // Program polls the target; ID reads the chosen offset
                  s_d.st      = S_RD_WAIT;
                  s_d.polling = (s_q.op == fcs_pkg::OP_PROG);
                  s_d.first   = 1'b1;
                  s_d.polls   = 16'h0;
                  s_d.cnt     = 16'h0;
                  s_d.f_addr  = s_q.addr_reg;
                  s_d.f_ce_n  = 1'b0;
                  s_d.f_oe_n  = 1'b0;
               end
            end else begin
               s_d.step = s_q.step + 2'h1;
               s_d.st   = S_WR_SET;
            end
         end
         S_RD_WAIT: begin
            s_d.cnt = s_q.cnt + 16'h1;
            if (s_q.cnt == 16'(fcs_pkg::RD_CYC - 1)) begin
               s_d.rdata  = s_q.dq_s2;
               s_d.f_ce_n = 1'b1;
               s_d.f_oe_n = 1'b1;
               s_d.st     = S_RD_GAP;
            end
         end
         S_RD_GAP: begin
            if (!s_q.polling) begin
               s_d.st   = S_IDLE;
               s_d.done = 1'b1;
            end else if (s_q.first ||
                         (s_q.rdata[fcs_pkg::TOGGLE_BIT] != s_q.prev[fcs_pkg::TOGGLE_BIT] &&
                          !s_q.rdata[fcs_pkg::TIME_LIMIT_BIT] &&
                          s_q.polls != 16'(POLL_MAX - 1))) begin
               // Still busy: read again so each strobe is a fresh one
               s_d.prev   = s_q.rdata;
               s_d.first  = 1'b0;
               s_d.polls  = s_q.polls + 16'h1;
               s_d.cnt    = 16'h0;
               s_d.st     = S_RD_WAIT;
               s_d.f_ce_n = 1'b0;
               s_d.f_oe_n = 1'b0;
            end else if (s_q.rdata[fcs_pkg::TOGGLE_BIT] == s_q.prev[fcs_pkg::TOGGLE_BIT] &&
                         s_q.rdata == s_q.wdata_reg) begin
               s_d.st   = S_IDLE;
               s_d.done = 1'b1;
            end else begin
               // Time limit, poll limit or bad verify: return flash to read mode
               s_d.fail = 1'b1;
               s_d.op   = fcs_pkg::OP_RSTCMD;
               s_d.step = 2'h0;
               s_d.st   = S_WR_SET;
            end
         end
      endcase
   end

   // Whole state in one register; pins idle and reset held released
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q           <= '0;
         s_q.st        <= S_RST_REC;
         s_q.addr_reg  <= fcs_pkg::ADDR_RST;
         s_q.wdata_reg <= fcs_pkg::WDATA_RST;
         s_q.f_ce_n    <= 1'b1;
         s_q.f_we_n    <= 1'b1;
         s_q.f_oe_n    <= 1'b1;
         s_q.f_rst_n   <= 1'b1;
         s_q.waitreq   <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign avs_readdata    = s_q.bus_rdata;
   assign avs_waitrequest = s_q.waitreq;
   assign flash_addr      = s_q.f_addr;
   assign flash_dq_o      = s_q.f_dq;
   assign flash_dq_oe     = s_q.f_dq_oe;
   assign flash_ce_n      = s_q.f_ce_n;
   assign flash_we_n      = s_q.f_we_n;
   assign flash_oe_n      = s_q.f_oe_n;
   assign flash_reset_n   = s_q.f_rst_n;

   // Checks on the pins the host drives
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   rst_low_width_a: assert property ($fell(s_q.f_rst_n) |-> !s_q.f_rst_n [*8] ##2 1)
      else $error("reset pin released early");
   rst_recovery_a: assert property (
      $rose(s_q.f_rst_n) |-> s_q.f_oe_n [*8] ##22 s_q.f_oe_n)
      else $error("read started during reset recovery");
   write_strobe_a: assert property (!s_q.f_we_n |-> !s_q.f_ce_n && s_q.f_oe_n && s_q.f_dq_oe)
      else $error("write strobe without chip enable or data");
   write_data_hold_a: assert property (
      $rose(s_q.f_we_n) |-> $stable(s_q.f_dq) && s_q.f_dq_oe && $stable(s_q.f_addr))
      else $error("data moved at write strobe release");
   prog_setup_cmd_a: assert property (
      s_q.st == S_WR_HOLD && s_q.op == fcs_pkg::OP_PROG && s_q.step == 2'h2 |->
      s_q.f_dq == fcs_pkg::CMD_PROGRAM && s_q.f_addr == fcs_pkg::UNLOCK1_ADDR)
      else $error("wrong program setup cycle");
   bus_answer_a: assert property ((avs_read || avs_write) && s_q.waitreq |=> !s_q.waitreq)
      else $error("bus access not answered next cycle");
   fail_reset_a: assert property (
      $rose(s_q.fail) |-> ##[1:14] (!s_q.f_we_n && s_q.f_dq == fcs_pkg::CMD_READ_RESET))
      else $error("no reset command after failure");
   id_read_addr_a: assert property (
      $fell(s_q.f_oe_n) && s_q.op == fcs_pkg::OP_ID |-> s_q.f_addr == s_q.addr_reg && s_q.f_we_n)
      else $error("identification read at wrong address");
   prog_done_c: cover property (s_q.op == fcs_pkg::OP_PROG && $rose(s_q.done));
   id_done_c: cover property (s_q.op == fcs_pkg::OP_ID && $rose(s_q.done));
   hw_reset_c: cover property ($rose(s_q.f_rst_n));
   prog_fail_c: cover property ($rose(s_q.fail));
endmodule // fcs_host

// ---- pkg/fcs_pkg.sv ----
// Constants for the flash command and status sequencer (host side).
// Assumes a 20 MHz clock and a byte-wide parallel flash with asynchronous strobes.
package fcs_pkg;
   // Software register word addresses
   localparam logic [1:0]  REG_CTRL       = 2'h0;
   localparam logic [1:0]  REG_ADDR       = 2'h1;
   localparam logic [1:0]  REG_WDATA      = 2'h2;
   localparam logic [1:0]  REG_STATUS     = 2'h3;
   // Operation codes written to the control register
   localparam logic [2:0]  OP_READ        = 3'h0;
   localparam logic [2:0]  OP_PROG        = 3'h1;
   localparam logic [2:0]  OP_ID          = 3'h2;
   localparam logic [2:0]  OP_RSTCMD      = 3'h3;
   localparam logic [2:0]  OP_HWRST       = 3'h4;
   // Unlock cycles and command codes, kept configurable
   localparam logic [17:0] UNLOCK1_ADDR   = 18'h00555;
   localparam logic [17:0] UNLOCK2_ADDR   = 18'h002aa;
   localparam logic [7:0]  UNLOCK1_DATA   = 8'haa;
   localparam logic [7:0]  UNLOCK2_DATA   = 8'h55;
   localparam logic [7:0]  CMD_PROGRAM    = 8'ha0;
   localparam logic [7:0]  CMD_ID_READ    = 8'h90;
   localparam logic [7:0]  CMD_READ_RESET = 8'hf0;
   // Identification read offsets (low address byte)
   localparam logic [7:0]  ID_MFR_OFS     = 8'h00;
   localparam logic [7:0]  ID_DEV_OFS     = 8'h01;
   localparam logic [7:0]  ID_PROT_OFS    = 8'h02;
   // Status bit positions on the flash data bus
   localparam int          TOGGLE_BIT     = 6;
   localparam int          TIME_LIMIT_BIT = 5;
   localparam int          PROTECT_BIT    = 0;
   // Software status register fields
   localparam int          ST_BUSY        = 8;
   localparam int          ST_DONE        = 9;
   localparam int          ST_FAIL        = 10;
   localparam int          ST_READY       = 11;
   // Reset values of software registers
   localparam logic [17:0] ADDR_RST       = 18'h00000;
   localparam logic [7:0]  WDATA_RST      = 8'h00;
   // Timing
   localparam int          CLK_NS         = 50;
   localparam int          T_ACC_NS       = 120;
   localparam int          T_RST_LOW_NS   = 500;
   localparam int          T_RST_REC_NS   = 1500;
   localparam int          SYNC_CYC       = 2;
   localparam int          RD_CYC         = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC + 1;
   localparam int          RST_LOW_CYC    = (T_RST_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int          RST_REC_CYC    = (T_RST_REC_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ---- verif/fcs_flash_model.sv ----
// Behavioural model of the byte-wide flash on the far side of the host controller.
// Assumes the host drives the strobes; the model answers with no clock of its own.
module fcs_flash_model #(
   parameter logic [7:0] MFR_CODE    = 8'h3c, // Arbitrary maker code
   parameter logic [7:0] DEV_CODE    = 8'h5a, // Arbitrary device code
   parameter logic [4:0] PROT_SECTOR = 5'h02,
   parameter int         PROG_NS     = 2000
) (
   input  wire logic [17:0] addr,
   input  wire logic [7:0]  dq_o,
   input  wire logic        dq_oe,
   input  wire logic        ce_n,
   input  wire logic        we_n,
   input  wire logic        oe_n,
   input  wire logic        reset_n,
   output logic      [7:0]  dq_i,
   output logic             ready_busy_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  mem [logic [17:0]];
   int          mode   = 0; // 0 read, 1 id, 2 busy, 3 failed
   int          cnt    = 0;
   logic [17:0] wa, pa;
   logic [7:0]  pd, last = 8'h00;
   logic        wr_act = 1'b0, tog = 1'b0, rec_ok = 1'b1, chg = 1'b0;
   time         rst_t    = 0;
   logic        rst_seen = 1'b0;

   function automatic logic [7:0] rd(input logic [17:0] a);
      return mem.exists(a) ? mem[a] : 8'hff;
   endfunction

   // Command decoder; unlock values come from the shared constants
   task automatic cmd(input logic [17:0] a, input logic [7:0] d);
      if (mode == 2) return;
      // Internal state machine still resetting after a reset pin pulse
      if (rst_seen && $time - rst_t < 20000) return;
      if (d == fcs_pkg::CMD_READ_RESET && cnt != 3) begin
         mode = 0;
         cnt = 0;
         return;
      end
      if (mode == 3) return;
      case (cnt)
         0: cnt = (a == fcs_pkg::UNLOCK1_ADDR && d == fcs_pkg::UNLOCK1_DATA);
         1: cnt = (a == fcs_pkg::UNLOCK2_ADDR && d == fcs_pkg::UNLOCK2_DATA) ? 2 : 0;
         2: begin
            cnt = (d == fcs_pkg::CMD_PROGRAM) ? 3 : 0;
            if (d == fcs_pkg::CMD_ID_READ) mode = 1;
         end
         default: begin
            cnt = 0;
            pa = a;
            pd = d;
            // Bits can only be cleared; a set attempt fails
            if ((~rd(a) & d) != 8'h00) mode = 3;
            else begin
               mode = 2;
               mem[a] = rd(a) & d;
               chg = ~chg;
            end
         end
      endcase
   endtask

   // Address on the later falling strobe, data on the earlier rising one
   always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n && reset_n) begin
      wa = addr;
      wr_act = 1'b1;
   end
   always @(posedge we_n or posedge ce_n) if (wr_act) begin
      wr_act = 1'b0;
      // Undriven data bus carries no valid command
      cmd(wa, dq_oe ? dq_o : 8'hxx);
   end

   // Self-timed program
   initial forever begin
      wait (mode == 2);
      #(PROG_NS);
      if (mode == 2) mode = 0;
   end

   // Toggle bit flips per read while busy or failed
   // Either strobe may fall last in the same step; flip once both are low
   always @(negedge oe_n or negedge ce_n) if (!ce_n && !oe_n && mode >= 2) tog = ~tog;

   // Hardware reset aborts and corrupts the cell in flight
   always @(negedge reset_n) begin
      if (mode == 2) mem[pa] = 8'h00;
      rst_t = $time;
      rst_seen = 1'b1;
      mode = 0;
      cnt = 0;
      rec_ok = 1'b0;
      chg = ~chg;
   end
   always @(posedge reset_n) begin
      #1500;
      if (reset_n) rec_ok = 1'b1;
   end

   function automatic logic [7:0] rdout();
      if (mode == 1) begin
         case (addr[7:0])
            8'h00:   return MFR_CODE;
            8'h01:   return DEV_CODE;
            8'h02:   return {7'h00, addr[17:13] == PROT_SECTOR};
            default: return 8'hff;
         endcase
      end
      // Erase toggle stays still: no erase exists here
      if (mode >= 2) return {~pd[7], tog, mode == 3, 5'h00};
      return rd(addr);
   endfunction

   // A released bus shows the inverse of the last byte, never a held value
   always @(addr or mode or tog or ce_n or oe_n or reset_n or rec_ok or chg) begin
      if (!ce_n && !oe_n && reset_n && rec_ok) begin
         dq_i = rdout();
         last = dq_i;
      end else begin
         dq_i = ~last;
      end
   end
   assign ready_busy_n = (mode != 2);
endmodule // fcs_flash_model

// ---- verif/tb_top.sv ----
// Self-checking bench: software on the register port, flash model on the pins.
// Assumes the host answers each bus access once and finishes each op with done.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [17:0] A1 = 18'h01234;
   localparam logic [17:0] A2 = 18'h3fff0;
   logic        clk, rst_n, avs_read, avs_write, avs_waitrequest;
   logic [1:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [17:0] flash_addr;
   logic [7:0]  flash_dq_o, flash_dq_i;
   logic        flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, flash_reset_n;
   logic        flash_ready_busy_n;
   int          err_total = 0, num_checks = 0, busy_seen = 0;
   time         rst_fall = 0;

   fcs_host #(.POLL_MAX(8)) i_fcs_host (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .flash_addr(flash_addr),
      .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe), .flash_dq_i(flash_dq_i),
      .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
      .flash_reset_n(flash_reset_n), .flash_ready_busy_n(flash_ready_busy_n));
   fcs_flash_model #(.MFR_CODE(8'h3c), .DEV_CODE(8'h5a), .PROT_SECTOR(5'h02)) i_fcs_flash_model (
      .addr(flash_addr), .dq_o(flash_dq_o), .dq_oe(flash_dq_oe), .ce_n(flash_ce_n),
      .we_n(flash_we_n), .oe_n(flash_oe_n), .reset_n(flash_reset_n), .dq_i(flash_dq_i),
      .ready_busy_n(flash_ready_busy_n));

   // Free-running clock, 50 ns period
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Pin monitors for the reset pulse and the busy line
   always @(negedge flash_reset_n) rst_fall = $time;
   always @(posedge flash_reset_n) begin
      if (rst_n === 1'b1)
         chk_bit($time - rst_fall >= 500, 1'b1, "reset pulse short");
   end
   always @(negedge flash_ready_busy_n) busy_seen++;

   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic mismatch(input string m);
      err_total++;
      $display("ERROR %0t %s", $time, m);
   endtask
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
      num_checks++;
      if (got !== exp) mismatch(m);
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string m);
      num_checks++;
      if (got !== exp) mismatch(m);
   endtask

   // One Avalon access, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 50) begin
         mismatch("bus hang");
         print_verdict();
      end
   endtask
   task automatic wait_done(output logic [31:0] st);
      int n;
      n = 0;
      do begin
         bus(1'b0, fcs_pkg::REG_STATUS, 32'h0, st);
         n++;
      end while (!(st[fcs_pkg::ST_BUSY] === 1'b0 && st[fcs_pkg::ST_DONE] === 1'b1) && n < 2000);
      if (n >= 2000) begin
         mismatch("op hang");
         print_verdict();
      end
   endtask
   task automatic run_op(input logic [2:0] op, input logic [17:0] a, input logic [7:0] d,
                         output logic [31:0] st);
      logic [31:0] q;
      bus(1'b1, fcs_pkg::REG_ADDR, {14'h0, a}, q);
      bus(1'b1, fcs_pkg::REG_WDATA, {24'h0, d}, q);
      bus(1'b1, fcs_pkg::REG_CTRL, {29'h0, op}, q);
      wait_done(st);
   endtask

   task automatic sc_power_up();
      logic [31:0] st;
      wait_done(st);
      chk_bit(st[fcs_pkg::ST_READY], 1'b1, "not ready");
      run_op(fcs_pkg::OP_READ, A1, 8'h00, st);
      chk_byte(st[7:0], 8'hff, "erased read");
   endtask
   task automatic sc_program();
      logic [31:0] st;
      int b0;
      b0 = busy_seen;
      run_op(fcs_pkg::OP_PROG, A1, 8'h5a, st);
      chk_bit(st[fcs_pkg::ST_FAIL], 1'b0, "program fail");
      chk_bit(busy_seen > b0, 1'b1, "no busy");
      run_op(fcs_pkg::OP_READ, A1, 8'h00, st);
      chk_byte(st[7:0], 8'h5a, "program data");
      run_op(fcs_pkg::OP_PROG, A2, 8'ha5, st);
      run_op(fcs_pkg::OP_READ, A2, 8'h00, st);
      chk_byte(st[7:0], 8'ha5, "top sector data");
   endtask
   task automatic sc_set_bits();
      logic [31:0] st;
      run_op(fcs_pkg::OP_PROG, A1, 8'hff, st);
      chk_bit(st[fcs_pkg::ST_FAIL], 1'b1, "no fail");
      run_op(fcs_pkg::OP_READ, A1, 8'h00, st);
      chk_byte(st[7:0], 8'h5a, "bits set");
   endtask
   task automatic sc_ident();
      logic [31:0] st;
      logic [17:0] ia [4] = '{18'h00000, 18'h00001, 18'h04002, 18'h00002};
      logic [7:0]  ie [4] = '{8'h3c, 8'h5a, 8'h01, 8'h00};
      for (int i = 0; i < 4; i++) begin
         run_op(fcs_pkg::OP_ID, ia[i], 8'h00, st);
         chk_byte(st[7:0], ie[i], "id byte");
      end
      run_op(fcs_pkg::OP_RSTCMD, A1, 8'h00, st);
      run_op(fcs_pkg::OP_READ, A1, 8'h00, st);
      chk_byte(st[7:0], 8'h5a, "id exit");
   endtask
   task automatic sc_hw_reset();
      logic [31:0] st, q;
      run_op(fcs_pkg::OP_HWRST, A1, 8'h00, st);
      chk_bit(st[fcs_pkg::ST_FAIL], 1'b0, "reset fail");
      run_op(fcs_pkg::OP_READ, A1, 8'h00, st);
      chk_byte(st[7:0], 8'h5a, "read after reset");
      // Unknown op code is refused and leaves done standing
      bus(1'b1, fcs_pkg::REG_CTRL, 32'h5, q);
      bus(1'b0, fcs_pkg::REG_STATUS, 32'h0, st);
      chk_bit(st[fcs_pkg::ST_DONE], 1'b1, "bad op ran");
   endtask

   // Main sequence
   initial begin
      rst_n = 1'b0;
      avs_address = 2'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      sc_power_up();
      sc_program();
      sc_set_bits();
      sc_ident();
      sc_hw_reset();
      print_verdict();
   end
endmodule // tb_top
